// ===== hw/motor_pwm_state_controller.v
// brush motor PWM state controller: mode sensing, sleep/run/fault, duty, APB slave
// assumes comparator bits arrive unsynchronised and supply/command words from a
// converter on core_clk
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ns
`include "motor_pwm_regs.vh"

module motor_pwm_state_controller #(
   parameter OSC_DIV = `CORE_CLK_HZ / `OSC_NOM_HZ,
   parameter IDLE_TICKS = `IDLE_TICKS,
   parameter WINDOW_TICKS = `WINDOW_TICKS,
   parameter DISABLE_TICKS = `DISABLE_TICKS
) (
   input wire core_clk,
   input wire reset,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output reg pslverr,
   input wire manualSelectHigh,
   input wire autoCommandLevel,
   input wire overvoltageThreshold,
   input wire undervoltageThreshold,
   input wire currentSenseAboveLimit,
   input wire [15:0] supplyMv,
   input wire [11:0] manualDiffMv,
   output reg gate_drive_out,
   output reg integratorPullLow,
   output reg autoPullupEn,
   output reg manualSinkEn,
   output reg switchedReferenceOn
);

   reg [2:0] state_reg;
   reg [2:0] state_next;
   reg [4:0] sync1_reg;
   reg [4:0] sync2_reg;
   reg autoPrev_reg;
   reg manualMode_reg;
   reg [15:0] divCnt_reg;
   reg oscTick;
   reg [11:0] idleCnt_reg;
   reg [16:0] windowCnt_reg;
   reg windowFlag_reg;
   reg [3:0] flaggedCnt_reg;
   reg restartUsed_reg;
   reg [16:0] disableCnt_reg;
   reg signed [15:0] speedInt_reg;
   reg [15:0] numer_reg;
   reg [24:0] dividend_reg;
   reg [16:0] rem_reg;
   reg [24:0] quot_reg;
   reg [4:0] divStep_reg;
   reg [10:0] duty_reg;
   reg [15:0] thresh_reg;
   reg forceSleep_reg;
   wire manHigh;
   wire autoLevel;
   wire overV;
   wire underV;
   wire senseAbove;
   wire autoFall;
   wire autoIdle;
   wire windowEnd;
   wire overCurrent;
   wire sleepCause;
   wire intPull;
   wire signed [15:0] intTarget;
   wire signed [15:0] intStep;
   wire [27:0] manScaled;
   wire [16:0] remShift;
   wire [26:0] threshProd;
   wire apbWrite;

   // first stage is read only by the second stage
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         sync1_reg <= 5'h00;
         sync2_reg <= 5'h00;
      end else begin
         sync1_reg <= {manualSelectHigh, autoCommandLevel, overvoltageThreshold,
                       undervoltageThreshold, currentSenseAboveLimit};
         sync2_reg <= sync1_reg;
      end
   end

   assign manHigh = sync2_reg[4];
   assign autoLevel = sync2_reg[3];
   assign overV = sync2_reg[2];
   assign underV = sync2_reg[1];
   assign senseAbove = sync2_reg[0];

   // oscillator tick divider; also the PWM phase counter
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         divCnt_reg <= 16'h0000;
         oscTick <= 1'b0;
      end else if (divCnt_reg == OSC_DIV[15:0] - 16'h0001) begin
         divCnt_reg <= 16'h0000;
         oscTick <= 1'b1;
      end else begin
         divCnt_reg <= divCnt_reg + 16'h0001;
         oscTick <= 1'b0;
      end
   end

   // mode comes from the wiring: a select input pulled above the supply means manual
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         manualMode_reg <= 1'b0;
      end else if (state_reg == `ST_SLEEP) begin
         manualMode_reg <= manHigh;
      end
   end

   // falling edge of the pulsed command, and its inactivity timer
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         autoPrev_reg <= 1'b0;
         idleCnt_reg <= 12'h000;
      end else begin
         autoPrev_reg <= autoLevel;
         if (autoFall || autoLevel != autoPrev_reg) begin
            idleCnt_reg <= 12'h000;
         end else if (oscTick && !autoIdle) begin
            idleCnt_reg <= idleCnt_reg + 12'h001;
         end
      end
   end

   assign autoFall = autoPrev_reg && !autoLevel;
   // a static level (constant high is the zero-speed command) counts as idle
   assign autoIdle = (idleCnt_reg == IDLE_TICKS[11:0] - 12'h001) && oscTick;

   // any route to sleep; the latched current fault also clears this way
   assign sleepCause = underV || forceSleep_reg ||
                       (manualMode_reg ? !manHigh : autoIdle);

   // overcurrent is only meaningful while the gate is actually on
   assign overCurrent = senseAbove && gate_drive_out;
   assign windowEnd = oscTick && (windowCnt_reg == WINDOW_TICKS[16:0] - 17'h00001);

   // state machine
   always @* begin
      state_next = state_reg;
      case (state_reg)
         `ST_SLEEP: begin
            if (!underV && !forceSleep_reg) begin
               if (manHigh) begin
                  state_next = `ST_RUN;
               end else if (autoFall) begin
                  state_next = `ST_RUN;
               end
            end
         end
         `ST_RUN: begin
            if (sleepCause) begin
               state_next = `ST_SLEEP;
            end else if (overV) begin
               state_next = `ST_FAULT_OV;
            end else if (windowEnd && (windowFlag_reg || overCurrent) &&
                         flaggedCnt_reg == `FLAGGED_WINDOWS - 4'h1) begin
               state_next = restartUsed_reg ? `ST_FAULT_LATCH : `ST_FAULT_OFF;
            end
         end
         `ST_FAULT_OV: begin
            if (sleepCause) begin
               state_next = `ST_SLEEP;
            end else if (!overV) begin
               state_next = `ST_RUN;
            end
         end
         `ST_FAULT_OFF: begin
            if (sleepCause) begin
               state_next = `ST_SLEEP;
            end else if (oscTick && disableCnt_reg == DISABLE_TICKS[16:0] - 17'h00001) begin
               state_next = `ST_RUN;
            end
         end
         `ST_FAULT_LATCH: begin
            if (sleepCause) begin
               state_next = `ST_SLEEP;
            end
         end
         default: begin
            state_next = `ST_SLEEP;
         end
      endcase
   end

   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         state_reg <= `ST_SLEEP;
      end else begin
         state_reg <= state_next;
      end
   end

   // overcurrent windows and the shutdown/restart history
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         windowCnt_reg <= 17'h00000;
         windowFlag_reg <= 1'b0;
         flaggedCnt_reg <= 4'h0;
         restartUsed_reg <= 1'b0;
         disableCnt_reg <= 17'h00000;
      end else if (state_reg != `ST_RUN) begin
         windowCnt_reg <= 17'h00000;
         windowFlag_reg <= 1'b0;
         flaggedCnt_reg <= 4'h0;
         if (state_reg == `ST_SLEEP) begin
            restartUsed_reg <= 1'b0;
         end else if (state_reg == `ST_FAULT_OFF) begin
            restartUsed_reg <= 1'b1;
         end
         if (state_reg == `ST_FAULT_OFF && oscTick) begin
            disableCnt_reg <= disableCnt_reg + 17'h00001;
         end else if (state_reg != `ST_FAULT_OFF) begin
            disableCnt_reg <= 17'h00000;
         end
      end else begin
         disableCnt_reg <= 17'h00000;
         if (windowEnd) begin
            windowCnt_reg <= 17'h00000;
            windowFlag_reg <= 1'b0;
            if (windowFlag_reg || overCurrent) begin
               flaggedCnt_reg <= flaggedCnt_reg + 4'h1;
            end else begin
               flaggedCnt_reg <= 4'h0;
               restartUsed_reg <= 1'b0;
            end
         end else begin
            if (oscTick) begin
               windowCnt_reg <= windowCnt_reg + 17'h00001;
            end
            if (overCurrent) begin
               windowFlag_reg <= 1'b1;
            end
         end
      end
   end

   // digital stand-in for the speed integrator; pulled low rather than frozen
   // so that duty ramps up gently on recovery
   assign intPull = (state_reg != `ST_RUN) || overCurrent;
   assign manScaled = {16'h0000, manualDiffMv} * 28'd`MAN_GAIN_Q10;
   // low on the pulsed input is speed: less high time means faster
   assign intTarget = manualMode_reg ? $signed({1'b0, manScaled[24:10]}) :
                      (autoLevel ? 16'sd0 : 16'sd`AUTO_SPAN_MV);
   assign intStep = (intTarget - speedInt_reg) >>> `INT_SHIFT;

   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         speedInt_reg <= 16'sd0;
      end else if (intPull) begin
         speedInt_reg <= 16'sd0;
      end else if (oscTick) begin
         speedInt_reg <= speedInt_reg + intStep;
      end
   end

   // serial divider: duty in 1/1024 = (offset + integrator) * 1024 / supply
   assign remShift = {rem_reg[15:0], dividend_reg[24]};

   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         numer_reg <= 16'h0000;
         dividend_reg <= 25'h0000000;
         rem_reg <= 17'h00000;
         quot_reg <= 25'h0000000;
         divStep_reg <= 5'h00;
         duty_reg <= 11'h000;
      end else if (oscTick && divStep_reg == 5'h00) begin
         // a new load waits for the divider to finish, so a tick period shorter
         // than the 25 division steps, other than 1, 2 or 13 cycles, still yields a duty, only less often
         numer_reg <= 16'd`OFFSET_MV + speedInt_reg[15:0];
         dividend_reg <= {numer_reg[14:0], 10'h000};
         rem_reg <= 17'h00000;
         quot_reg <= 25'h0000000;
         divStep_reg <= 5'd25;
      end else if (divStep_reg != 5'h00) begin
         dividend_reg <= {dividend_reg[23:0], 1'b0};
         divStep_reg <= divStep_reg - 5'h01;
         if (remShift >= {1'b0, supplyMv} && supplyMv != 16'h0000) begin
            rem_reg <= remShift - {1'b0, supplyMv};
            quot_reg <= {quot_reg[23:0], 1'b1};
         end else begin
            rem_reg <= remShift;
            quot_reg <= {quot_reg[23:0], 1'b0};
         end
      end else begin
         // saturate at full on
         duty_reg <= (quot_reg > 25'd1024) ? 11'd1024 : quot_reg[10:0];
      end
   end

   // compare threshold, rescaled to the phase counter once per period
   assign threshProd = {16'h0000, duty_reg} * OSC_DIV[26:0];

   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         thresh_reg <= 16'h0000;
      end else if (oscTick) begin
         thresh_reg <= threshProd[25:10];
      end
   end

   // outputs: gate only in run, only below the threshold
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         gate_drive_out <= 1'b0;
         integratorPullLow <= 1'b1;
         autoPullupEn <= 1'b0;
         manualSinkEn <= 1'b0;
         switchedReferenceOn <= 1'b0;
      end else begin
         gate_drive_out <= (state_next == `ST_RUN) && !overV && !underV &&
                           (divCnt_reg < thresh_reg);
         integratorPullLow <= intPull;
         autoPullupEn <= (state_reg == `ST_RUN) && !manualMode_reg;
         manualSinkEn <= (state_reg == `ST_RUN) && manualMode_reg;
         switchedReferenceOn <= (state_reg != `ST_SLEEP);
      end
   end

   // APB slave, zero wait states
   assign pready = 1'b1;
   assign apbWrite = psel && penable && pwrite;

   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         forceSleep_reg <= `CTRL_RESET_VALUE;
      end else if (apbWrite && paddr == `CTRL_OFFSET) begin
         forceSleep_reg <= pwdata[`CTRL_FORCE_SLEEP_BIT];
      end
   end

   // read data and error are combinational so they are valid in the access phase
   always @* begin
      prdata = 32'h00000000;
      pslverr = 1'b0;
      if (psel && penable) begin
         case (paddr)
            `CTRL_OFFSET: prdata = {31'h00000000, forceSleep_reg};
            `STATUS_OFFSET: prdata = {22'h000000, restartUsed_reg, flaggedCnt_reg,
                                      manualMode_reg, gate_drive_out, state_reg};
            `DUTY_OFFSET: prdata = {21'h000000, duty_reg};
            `SPEED_OFFSET: prdata = {16'h0000, speedInt_reg};
            default: pslverr = 1'b1;
         endcase
      end
   end

endmodule

// ===== hw/motor_pwm_regs.vh
// constants of the brush motor PWM state controller: bus offsets, fields, timing
// assumes a 125 MHz core clock; counts are in oscillator ticks derived from it
//
// Contract
// - sense auto or manual wiring, decode accordingly
// - zero-speed auto command sends controller to sleep
// - manual open command inputs send controller to sleep
// - gate drive held low throughout sleep
// - valid speed command in sleep enters run
// - fault only from overvoltage or current fault
// - overvoltage enters fault, undervoltage enters sleep
// - gate off until supply returns to normal
// - integrator pulled low in overvoltage and sleep
// - all counts from 20 kHz oscillator ticks
// - falling auto edge wakes sleep into run
// - 100 Hz command, less high means faster
// - auto input static 2048 ticks gives sleep
// - auto pull-up only in automatic run
// - auto duty = (2.88+13.12(1-D))/Vbat
// - manual select high moves sleep to run
// - manual run enables twentyfold current sinks
// - manual duty = (2.88+6.56 Vdiff)/Vbat
// - manual select opening enters sleep
// - overcurrent only while gate high; pulls integrator
// - 8192-tick windows latch any overcurrent
// - eight flagged windows: off 65536 ticks, restart
// - second eight flagged windows: latch until sleep
// - clean window clears count and restart history
`ifndef MOTOR_PWM_REGS_VH
`define MOTOR_PWM_REGS_VH

// timing
`define CORE_CLK_HZ 125000000
`define OSC_NOM_HZ 20000
`define IDLE_TICKS 2048
`define WINDOW_TICKS 8192
`define DISABLE_TICKS 65536
`define FLAGGED_WINDOWS 4'h8

// transfer equations, millivolts
`define OFFSET_MV 2880
`define AUTO_SPAN_MV 13120
`define MAN_GAIN_Q10 6717
`define INT_SHIFT 6

// register offsets
`define CTRL_OFFSET 8'h00
`define STATUS_OFFSET 8'h04
`define DUTY_OFFSET 8'h08
`define SPEED_OFFSET 8'h0C

// fields
`define CTRL_FORCE_SLEEP_BIT 0
`define CTRL_RESET_VALUE 1'h0

// states
`define ST_SLEEP 3'h0
`define ST_RUN 3'h1
`define ST_FAULT_OV 3'h2
`define ST_FAULT_OFF 3'h3
`define ST_FAULT_LATCH 3'h4

`endif

// ===== verif/motor_pwm_state_controller_monitor.sv
// assertion checker for the motor PWM state controller, on its top ports only
// assumes a bind to every controller instance; one clock domain
`timescale 1ns/1ns
module motor_pwm_state_controller_monitor (
   input wire core_clk,
   input wire reset,
   input wire manualSelectHigh,
   input wire autoCommandLevel,
   input wire overvoltageThreshold,
   input wire undervoltageThreshold,
   input wire gate_drive_out,
   input wire integratorPullLow,
   input wire autoPullupEn,
   input wire manualSinkEn,
   input wire switchedReferenceOn
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);
   // a wake only counts once wiring and supply have settled past the synchronisers
   sequence quietAutoSleep;
      (!manualSelectHigh && !undervoltageThreshold && !overvoltageThreshold
         && !switchedReferenceOn)[*4];
   endsequence
   a_mode_exclusive: assert property (!(autoPullupEn && manualSinkEn))
      else $error("pull-up and sinks on together");
   a_pullup_awake: assert property (autoPullupEn |-> switchedReferenceOn)
      else $error("pull-up on while asleep");
   a_sinks_awake: assert property (manualSinkEn |-> switchedReferenceOn)
      else $error("sinks on while asleep");
   a_sleep_integ: assert property (!switchedReferenceOn |-> integratorPullLow)
      else $error("integrator released in sleep");
   a_sleep_gate: assert property (!switchedReferenceOn |-> !$past(gate_drive_out))
      else $error("gate high in sleep");
   a_ov_gate: assert property (overvoltageThreshold[*4] |-> !gate_drive_out)
      else $error("gate high in overvoltage");
   a_ov_integ: assert property (overvoltageThreshold[*4] |-> ##1 integratorPullLow)
      else $error("integrator released in overvoltage");
   a_uv_sleep: assert property (undervoltageThreshold[*4] |->
      !gate_drive_out ##1 !switchedReferenceOn)
      else $error("undervoltage did not sleep");
   a_auto_wake: assert property (quietAutoSleep ##0 $fell(autoCommandLevel) |->
      ##[1:5] switchedReferenceOn)
      else $error("falling command edge did not wake");
   c_auto_run: cover property ($rose(autoPullupEn));
   c_manual_run: cover property ($rose(manualSinkEn));
   c_to_sleep: cover property ($fell(switchedReferenceOn));
endmodule
bind motor_pwm_state_controller motor_pwm_state_controller_monitor i_mon (
   .core_clk(core_clk), .reset(reset), .manualSelectHigh(manualSelectHigh),
   .autoCommandLevel(autoCommandLevel), .overvoltageThreshold(overvoltageThreshold),
   .undervoltageThreshold(undervoltageThreshold), .gate_drive_out(gate_drive_out),
   .integratorPullLow(integratorPullLow), .autoPullupEn(autoPullupEn),
   .manualSinkEn(manualSinkEn), .switchedReferenceOn(switchedReferenceOn));

// ===== verif/motor_far_side.sv
// far side: open-collector speed command source and the low-side switch
// assumes a pull-up on the command line, so a released line reads high
`timescale 1ns/1ns
module motor_far_side #(
   parameter PERIOD = 25
) (
   input wire core_clk,
   input wire gate_drive_out,
   input wire cmdOn,
   input wire [7:0] highCnt,
   input wire overload,
   output logic autoCommandLevel,
   output logic currentSenseAboveLimit
);
   logic [7:0] phase;
   initial begin
      phase = 8'h00;
      autoCommandLevel = 1'b1;
      currentSenseAboveLimit = 1'b0;
   end
   // fixed-rate train, line pulled low outside highCnt; sense only while switch conducts
   always @(posedge core_clk) begin
      phase <= (phase == 8'(PERIOD - 1)) ? 8'h00 : phase + 8'h01;
      autoCommandLevel <= !cmdOn || (phase < highCnt);
      currentSenseAboveLimit <= overload && gate_drive_out;
   end
endmodule

// ===== verif/testbench.sv
// self-checking bench for the motor PWM state controller
// assumes shortened tick counts; APB reads leave notes for a watcher process
`timescale 1ns/1ns
module testbench;
   logic core_clk, reset, psel, penable, pwrite, pready, pslverr, manualSelectHigh;
   logic autoCommandLevel, overvoltageThreshold, undervoltageThreshold, cmdOn, overload;
   logic currentSenseAboveLimit, gate_drive_out, integratorPullLow, autoPullupEn;
   logic manualSinkEn, switchedReferenceOn;
   logic [7:0] paddr, highCnt;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] supplyMv;
   logic [11:0] manualDiffMv;
   logic [33:0] notes[$];
   logic [33:0] note;
   int mismatches = 0;
   int samples_checked = 0;

   motor_pwm_state_controller #(.OSC_DIV(16), .IDLE_TICKS(16), .WINDOW_TICKS(32),
      .DISABLE_TICKS(64)) i_motor_pwm_state_controller (.core_clk(core_clk),
      .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .manualSelectHigh(manualSelectHigh), .autoCommandLevel(autoCommandLevel),
      .overvoltageThreshold(overvoltageThreshold),
      .undervoltageThreshold(undervoltageThreshold),
      .currentSenseAboveLimit(currentSenseAboveLimit), .supplyMv(supplyMv),
      .manualDiffMv(manualDiffMv), .gate_drive_out(gate_drive_out),
      .integratorPullLow(integratorPullLow), .autoPullupEn(autoPullupEn),
      .manualSinkEn(manualSinkEn), .switchedReferenceOn(switchedReferenceOn));
   motor_far_side #(.PERIOD(25)) i_motor_far_side (.core_clk(core_clk),
      .gate_drive_out(gate_drive_out), .cmdOn(cmdOn), .highCnt(highCnt),
      .overload(overload), .autoCommandLevel(autoCommandLevel),
      .currentSenseAboveLimit(currentSenseAboveLimit));

   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   task automatic check(input logic [32:0] seen, input logic [32:0] want);
      samples_checked++;
      if (seen !== want) begin
         mismatches++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask

   task automatic conclude;
      $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
      if (mismatches == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // one APB transfer; a read leaves a note (compare flag, pslverr, prdata)
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
         input logic chk, input logic [32:0] want);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      if (!wr) notes.push_back({chk, want});
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask

   // poll the state field with a bounded number of reads
   task automatic wait_state(input logic [2:0] st, input int lim);
      int n;
      n = 0;
      do begin
         apb(1'b0, 8'h04, 32'h0, 1'b0, 33'h0);
         n++;
      end while (rd[2:0] !== st && n < lim);
      check({30'h0, rd[2:0]}, {30'h0, st});
   endtask

   task automatic wait_ref(input logic v, input int lim);
      int n;
      n = 0;
      while (switchedReferenceOn !== v && n < lim) begin
         @(posedge core_clk);
         n++;
      end
      check(switchedReferenceOn, v);
   endtask

   // watcher: every completed read takes the oldest note
   always @(posedge core_clk)
      if (psel && penable && pready && !pwrite && notes.size() > 0) begin
         note = notes.pop_front();
         if (note[33]) check({pslverr, prdata}, note[32:0]);
      end

   // watchdog sized well above the longest fault sequence
   initial begin
      repeat (60000) @(posedge core_clk);
      mismatches++;
      conclude;
   end

   initial begin
      reset = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      manualSelectHigh = 1'b0;
      overvoltageThreshold = 1'b0;
      undervoltageThreshold = 1'b0;
      cmdOn = 1'b0;
      overload = 1'b0;
      rd = $urandom(1);
      supplyMv = 16'(9000 + $urandom % 6000);
      // command kept high enough that gate pulses outlast the sense path delay
      manualDiffMv = 12'(1200 + $urandom % 1000);
      highCnt = 8'(2 + $urandom % 20);
      repeat (20) @(posedge core_clk);
      reset <= 1'b0;
      apb(1'b0, 8'h00, 32'h0, 1'b1, 33'h0);
      apb(1'b1, 8'h04, 32'hFFFFFFFF, 1'b0, 33'h0);
      apb(1'b0, 8'h04, 32'h0, 1'b1, 33'h0);
      apb(1'b0, 8'h20, 32'h0, 1'b1, {1'b1, 32'h0});
      cmdOn <= 1'b1;
      wait_ref(1'b1, 200);
      check({autoPullupEn, manualSinkEn, integratorPullLow}, 33'h4);
      overvoltageThreshold <= 1'b1;
      wait_state(3'h2, 50);
      check(integratorPullLow, 1'b1);
      overvoltageThreshold <= 1'b0;
      wait_state(3'h1, 50);
      cmdOn <= 1'b0;
      repeat (200) @(posedge core_clk);
      check(switchedReferenceOn, 1'b1);
      wait_ref(1'b0, 120);
      manualSelectHigh <= 1'b1;
      wait_ref(1'b1, 50);
      check({autoPullupEn, manualSinkEn}, 33'h1);
      manualSelectHigh <= 1'b0;
      wait_ref(1'b0, 50);
      undervoltageThreshold <= 1'b1;
      manualSelectHigh <= 1'b1;
      repeat (30) @(posedge core_clk);
      check(switchedReferenceOn, 1'b0);
      undervoltageThreshold <= 1'b0;
      wait_ref(1'b1, 50);
      apb(1'b1, 8'h00, 32'h1, 1'b0, 33'h0);
      wait_ref(1'b0, 50);
      apb(1'b0, 8'h00, 32'h0, 1'b1, 33'h1);
      apb(1'b1, 8'h00, 32'h0, 1'b0, 33'h0);
      wait_ref(1'b1, 50);
      overload <= 1'b1;
      repeat (3000) @(posedge core_clk);
      overload <= 1'b0;
      repeat (1100) @(posedge core_clk);
      overload <= 1'b1;
      repeat (3000) @(posedge core_clk);
      wait_state(3'h1, 1);
      wait_state(3'h3, 1500);
      repeat (700) @(posedge core_clk);
      wait_state(3'h3, 1);
      wait_state(3'h1, 600);
      wait_state(3'h4, 3000);
      overload <= 1'b0;
      repeat (3000) @(posedge core_clk);
      wait_state(3'h4, 1);
      // integrator held at zero leaves only the fixed offset over the supply
      apb(1'b0, 8'h08, 32'h0, 1'b1, {1'b0, 32'(2880 * 1024 / supplyMv)});
      apb(1'b0, 8'h0C, 32'h0, 1'b1, 33'h0);
      manualSelectHigh <= 1'b0;
      wait_ref(1'b0, 50);
      manualSelectHigh <= 1'b1;
      wait_ref(1'b1, 50);
      wait_state(3'h1, 1);
      conclude;
   end
endmodule
